// ==== ccca_alu.v ====
// Purpose: Execution of compare, clear, complement and flag-clear instructions.
// Assumes: The sequencer presents an opcode and, for memory forms, the fetched operand.
// Notes: Memory results are handed back on mem_wdata_o for the sequencer to write.
`timescale 1ns/10ps
`default_nettype none
`include "ccca_regs.vh"

// What this block does
// - The accumulator compare subtracts B from A for flags only and writes no result.
// - The memory compares subtract the memory operand from A (81) or B (C1) and set flags.
// - Compares leave both accumulators and memory operands unchanged.
// - For compare and complement, N is result bit 7 and Z is set only for an all-zero result.
// - Compare overflow is set when operand signs differ and the result sign differs from the minuend (A, or B for the B compares).
// - Compare carry is the borrow out of bit 7 by the three-term formula.
// - Clear-carry (0C) forces C to zero on the single clock edge that takes the opcode.
// - Clear-overflow (0A) forces V to zero and leaves other flags alone.
// - Clear-interrupt-mask (0E) forces I to zero, enabling maskable interrupts.
// - The mask clearing takes effect one E-clock cycle late.
// - If previously masked, the following instruction always runs before a pending interrupt.
// - Clear zeroes the accumulator or memory operand, sets Z and clears N, V and C.
// - Complement inverts every bit of the accumulator or memory operand.
// - After complement V is cleared and C is set.
module ccca_alu (
  input wire core_clk_i, // E clock
  input wire rst_n_i, // asynchronous reset, active low
  input wire clk_en_i, // freezes all state while low
  input wire exec_i, // one-cycle pulse: execute opcode_i now
  input wire [7:0] opcode_i, // opcode of instruction to execute
  input wire [7:0] mem_operand_i, // fetched memory or immediate operand
  input wire insn_boundary_i, // pulse at each instruction completion
  input wire irq_pending_i, // maskable interrupt request level
  output reg [7:0] accumulator_a_o, // accumulator A
  output reg [7:0] accumulator_b_o, // accumulator B
  output reg [7:0] condition_code_register_o, // condition code register
  output reg [7:0] mem_wdata_o, // result for memory-form clear/complement
  output reg mem_write_o, // pulse: mem_wdata_o must be written back
  output reg illegal_o, // pulse: opcode not handled here
  output wire irq_take_o // interrupt may be serviced now
);

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  // Every addressing form of a memory compare lands here with its operand already
  // fetched, so the forms differ only in their opcode byte.
  wire is_compare_ab = (opcode_i == `CCCA_OP_COMPARE_AB);
  wire is_compare_a = (opcode_i == `CCCA_OP_COMPARE_A_IMM) ||
    (opcode_i == `CCCA_OP_COMPARE_A_DIR) ||
    (opcode_i == `CCCA_OP_COMPARE_A_EXT) || (opcode_i == `CCCA_OP_COMPARE_A_IDX);
  wire is_compare_b = (opcode_i == `CCCA_OP_COMPARE_B_IMM) ||
    (opcode_i == `CCCA_OP_COMPARE_B_DIR) ||
    (opcode_i == `CCCA_OP_COMPARE_B_EXT) || (opcode_i == `CCCA_OP_COMPARE_B_IDX);

  // ----------------------------------------
  // Subtractor shared by all compares
  // ----------------------------------------
  reg [7:0] minuend;
  reg [7:0] subtrahend;
  wire [7:0] diff = minuend - subtrahend;

  always @*
  begin
    minuend = accumulator_b_o;
    subtrahend = mem_operand_i;
    if (is_compare_ab)
    begin
      minuend = accumulator_a_o;
      subtrahend = accumulator_b_o;
    end
    else if (is_compare_a)
    begin
      minuend = accumulator_a_o;
    end
  end

  // The flags come from bit 7 terms rather than a ninth adder bit, so the same
  // expressions read directly against the flag formulas.
  wire sub_v = (minuend[7] & ~subtrahend[7] & ~diff[7]) |
    (~minuend[7] & subtrahend[7] & diff[7]);
  wire sub_c = (~minuend[7] & subtrahend[7]) | (subtrahend[7] & diff[7]) |
    (diff[7] & ~minuend[7]);

  // ----------------------------------------
  // Next-state computation
  // ----------------------------------------
  reg [7:0] next_a;
  reg [7:0] next_b;
  reg [7:0] next_cond;
  reg [7:0] next_wdata;
  reg next_write;
  reg next_illegal;
  reg next_mask_clear;
  reg [7:0] inv_res;

  always @*
  begin
    next_a = accumulator_a_o;
    next_b = accumulator_b_o;
    next_cond = condition_code_register_o;
    next_wdata = mem_wdata_o;
    next_write = 1'b0;
    next_illegal = 1'b0;
    next_mask_clear = 1'b0;
    inv_res = 8'h00;
    if (exec_i)
    begin
      if (is_compare_ab || is_compare_a || is_compare_b)
      begin
        // Accumulators stay as they are; only flags move.
        next_cond[`CCCA_CC_N] = diff[7];
        next_cond[`CCCA_CC_Z] = (diff == 8'h00);
        next_cond[`CCCA_CC_V] = sub_v;
        next_cond[`CCCA_CC_C] = sub_c;
      end
      else
      begin
        case (opcode_i)
          `CCCA_OP_CLEAR_CARRY: next_cond[`CCCA_CC_C] = 1'b0;
          `CCCA_OP_CLEAR_OVF: next_cond[`CCCA_CC_V] = 1'b0;
          `CCCA_OP_CLEAR_MASK: next_mask_clear = 1'b1;
          `CCCA_OP_CLEAR_A, `CCCA_OP_CLEAR_B, `CCCA_OP_CLEAR_EXT, `CCCA_OP_CLEAR_IDX:
          begin
            if (opcode_i == `CCCA_OP_CLEAR_A)
              next_a = 8'h00;
            else if (opcode_i == `CCCA_OP_CLEAR_B)
              next_b = 8'h00;
            else
            begin
              // The memory byte is written by the sequencer from mem_wdata_o.
              next_wdata = 8'h00;
              next_write = 1'b1;
            end
            next_cond[`CCCA_CC_N] = 1'b0;
            next_cond[`CCCA_CC_Z] = 1'b1;
            next_cond[`CCCA_CC_V] = 1'b0;
            next_cond[`CCCA_CC_C] = 1'b0;
          end
          `CCCA_OP_INVERT_A, `CCCA_OP_INVERT_B, `CCCA_OP_INVERT_EXT, `CCCA_OP_INVERT_IDX:
          begin
            if (opcode_i == `CCCA_OP_INVERT_A)
              inv_res = ~accumulator_a_o;
            else if (opcode_i == `CCCA_OP_INVERT_B)
              inv_res = ~accumulator_b_o;
            else
              inv_res = ~mem_operand_i;
            if (opcode_i == `CCCA_OP_INVERT_A)
              next_a = inv_res;
            else if (opcode_i == `CCCA_OP_INVERT_B)
              next_b = inv_res;
            else
            begin
              next_wdata = inv_res;
              next_write = 1'b1;
            end
            next_cond[`CCCA_CC_N] = inv_res[7];
            next_cond[`CCCA_CC_Z] = (inv_res == 8'h00);
            next_cond[`CCCA_CC_V] = 1'b0;
            // Carry is forced set so older code that tests it after an inversion
            // still behaves; software wanting carry kept must use an exclusive-or.
            next_cond[`CCCA_CC_C] = 1'b1;
          end
          default: next_illegal = 1'b1;
        endcase
      end
    end
  end

  // ----------------------------------------
  // Delayed interrupt-mask clear
  // ----------------------------------------
  // The mask bit drops one cycle after the instruction, and the gate below also
  // holds off service until the next instruction has completed, so code such as
  // a clear-mask followed by a wait still runs that instruction first.
  reg mask_clear_pend;
  reg hold_one_insn;

  always @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      accumulator_a_o <= `CCCA_ACC_RST;
      accumulator_b_o <= `CCCA_ACC_RST;
      condition_code_register_o <= `CCCA_COND_RST;
      mem_wdata_o <= 8'h00;
      mem_write_o <= 1'b0;
      illegal_o <= 1'b0;
      mask_clear_pend <= 1'b0;
      hold_one_insn <= 1'b0;
    end
    else if (clk_en_i)
    begin
      accumulator_a_o <= next_a;
      accumulator_b_o <= next_b;
      condition_code_register_o <= next_cond;
      mem_wdata_o <= next_wdata;
      mem_write_o <= next_write;
      illegal_o <= next_illegal;
      mask_clear_pend <= next_mask_clear;
      if (mask_clear_pend)
        condition_code_register_o[`CCCA_CC_I] <= 1'b0;
      if (next_mask_clear && condition_code_register_o[`CCCA_CC_I])
        hold_one_insn <= 1'b1;
      else if (insn_boundary_i && !mask_clear_pend)
        hold_one_insn <= 1'b0;
    end
  end

  assign irq_take_o = irq_pending_i && !condition_code_register_o[`CCCA_CC_I] &&
    !hold_one_insn;

endmodule
`default_nettype wire

// ==== ccca_regs.vh ====
// Purpose: Constants for the compare, clear and complement execution block.
// Assumes: 8-bit data path, condition code byte ordered S X H I N Z V C.
// Notes: Opcodes are the single-byte encodings handled by the block.
`ifndef CCCA_REGS_VH
`define CCCA_REGS_VH

// ----------------------------------------
// Condition code bit positions
// ----------------------------------------
`define CCCA_CC_C 0
`define CCCA_CC_V 1
`define CCCA_CC_Z 2
`define CCCA_CC_N 3
`define CCCA_CC_I 4
`define CCCA_CC_H 5
`define CCCA_CC_X 6
`define CCCA_CC_S 7

// ----------------------------------------
// Reset values
// ----------------------------------------
`define CCCA_COND_RST 8'hd0
`define CCCA_ACC_RST 8'h00

// ----------------------------------------
// Opcodes
// ----------------------------------------
`define CCCA_OP_COMPARE_AB 8'h11
`define CCCA_OP_COMPARE_A_IMM 8'h81
`define CCCA_OP_COMPARE_B_IMM 8'hc1
`define CCCA_OP_COMPARE_A_DIR 8'h91
`define CCCA_OP_COMPARE_B_DIR 8'hd1
`define CCCA_OP_COMPARE_A_EXT 8'hb1
`define CCCA_OP_COMPARE_B_EXT 8'hf1
`define CCCA_OP_COMPARE_A_IDX 8'ha1
`define CCCA_OP_COMPARE_B_IDX 8'he1
`define CCCA_OP_CLEAR_CARRY 8'h0c
`define CCCA_OP_CLEAR_OVF 8'h0a
`define CCCA_OP_CLEAR_MASK 8'h0e
`define CCCA_OP_CLEAR_A 8'h4f
`define CCCA_OP_CLEAR_B 8'h5f
`define CCCA_OP_CLEAR_EXT 8'h7f
`define CCCA_OP_CLEAR_IDX 8'h6f
`define CCCA_OP_INVERT_A 8'h43
`define CCCA_OP_INVERT_B 8'h53
`define CCCA_OP_INVERT_EXT 8'h73
`define CCCA_OP_INVERT_IDX 8'h63

// ----------------------------------------
// Timing
// ----------------------------------------
`define CCCA_MASK_DELAY_CYC 1

`endif

// ==== ccca_alu_props.sv ====
// Purpose: Port-level checks for the compare, clear and complement unit.
// Assumes: One clock, asynchronous active-low reset.
// Notes: Every check keys on the edge at which an opcode is taken.
`timescale 1ns/10ps
`default_nettype none
module ccca_alu_props (
  input wire logic core_clk_i, // clock
  input wire logic rst_n_i, // reset, active low
  input wire logic clk_en_i, // enable
  input wire logic exec_i, // execute strobe
  input wire logic [7:0] opcode_i, // opcode
  input wire logic [7:0] mem_operand_i, // operand
  input wire logic [7:0] accumulator_a_o, // acc A
  input wire logic [7:0] accumulator_b_o, // acc B
  input wire logic [7:0] condition_code_register_o, // flags
  input wire logic irq_take_o // interrupt allowed
);
  wire go = exec_i && clk_en_i && rst_n_i;
  wire [7:0] cc = condition_code_register_o;
  wire [7:0] dif = accumulator_b_o - mem_operand_i;
  wire ovf = (accumulator_b_o[7] ^ mem_operand_i[7]) & (dif[7] ^ accumulator_b_o[7]);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  AST_AB_KEEP: assert property (go && opcode_i == 8'h11 |=>
    $stable(accumulator_a_o) && $stable(accumulator_b_o)) else $error("compare wrote back");
  AST_MEM_BORROW: assert property (go && opcode_i == 8'h81 |=>
    cc[0] == ($past(accumulator_a_o) < $past(mem_operand_i))) else $error("bad borrow");
  AST_MEM_OVF: assert property (go && opcode_i == 8'hc1 |=>
    cc[1] == $past(ovf)) else $error("bad compare overflow");
  // The mask bit is left out: a mask clear taken just before may still land here.
  AST_CARRY_CLEAR: assert property (go && opcode_i == 8'h0c |=>
    (cc & 8'hef) == ($past(cc) & 8'hee)) else $error("carry clear wrong");
  AST_OVF_CLEAR: assert property (go && opcode_i == 8'h0a |=>
    (cc & 8'hef) == ($past(cc) & 8'hed)) else $error("overflow clear wrong");
  AST_MASK_LATE: assert property (go && opcode_i == 8'h0e && cc[4] |=>
    cc[4] && !irq_take_o) else $error("mask cleared too early");
  AST_ZERO_A: assert property (go && opcode_i == 8'h4f |=>
    accumulator_a_o == 8'h00 && cc[3:0] == 4'h4) else $error("clear wrong");
  AST_INVERT_B: assert property (go && opcode_i == 8'h53 |=>
    accumulator_b_o == ~$past(accumulator_b_o) && cc[1:0] == 2'b01) else $error("invert wrong");
endmodule
bind ccca_alu ccca_alu_props i_ccca_alu_props (.*);
`default_nettype wire

// ==== ccca_mem_model.sv ====
// Purpose: One byte of data memory on the far side of the unit.
// Assumes: The bench preloads the byte before each instruction.
// Notes: A preload wins over write-back; the bench never issues both at once.
`timescale 1ns/10ps
`default_nettype none
module ccca_mem_model (
  input wire logic core_clk_i, // clock
  input wire logic load_i, // preload strobe
  input wire logic [7:0] load_data_i, // preload value
  input wire logic mem_write_i, // write-back strobe
  input wire logic [7:0] mem_wdata_i, // write-back data
  output logic [7:0] operand_o // stored byte
);
  always @(posedge core_clk_i) operand_o <= load_i ? load_data_i : (mem_write_i ? mem_wdata_i : operand_o);
endmodule
`default_nettype wire

// ==== ccca_alu_test.sv ====
// Purpose: Self-checking bench for the compare, clear and complement unit.
// Assumes: 250 MHz clock; the memory model supplies every operand.
// Notes: Rows hold opcode, operand, then expected A, B, flags and memory byte.
`timescale 1ns/10ps
`default_nettype none
module ccca_alu_test;
  logic clk = 1'b0, rst_n = 1'b0, en = 1'b1, exec = 1'b0, bnd = 1'b0, irq = 1'b1, ld = 1'b0;
  logic [7:0] opc = 8'h00, ldd = 8'h00;
  wire [7:0] opnd, acc_a, acc_b, cond, wdata;
  wire wr, take, ill;
  int fail_count = 0, tests_run = 0;
  logic [47:0] rows [13] = '{48'h4300ff00d900, 48'h1100ff00d800, 48'h81ffff00d4ff,
    48'hc180ff00db80, 48'h0a00ff00d900, 48'h0c00ff00d800, 48'h5300ffffd900, 48'h1100ffffd400,
    48'h4f0000ffd400, 48'h5f000000d400, 48'h735a0000d9a5, 48'h7f330000d400, 48'h817f0000d97f};
  ccca_alu i_ccca_alu (.core_clk_i(clk), .rst_n_i(rst_n), .clk_en_i(en), .exec_i(exec),
    .opcode_i(opc), .mem_operand_i(opnd), .insn_boundary_i(bnd), .irq_pending_i(irq),
    .accumulator_a_o(acc_a), .accumulator_b_o(acc_b), .condition_code_register_o(cond),
    .mem_wdata_o(wdata), .mem_write_o(wr), .illegal_o(ill), .irq_take_o(take));
  ccca_mem_model i_ccca_mem_model (.core_clk_i(clk), .load_i(ld), .load_data_i(ldd),
    .mem_write_i(wr), .mem_wdata_i(wdata), .operand_o(opnd));
  initial forever #2 clk = ~clk;
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    fail_count += (seen !== exp);
    if (seen !== exp)
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
  endtask
  task results;
    $display("tests_run %0d fail_count %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // The operand is preloaded a cycle early because the memory answers one edge late.
  task run(input logic [7:0] op, input logic [7:0] val);
    @(posedge clk) {ld, ldd} <= {1'b1, val};
    @(posedge clk) {ld, exec, opc} <= {1'b0, 1'b1, op};
    @(posedge clk) exec <= 1'b0;
    #1;
  endtask
  initial
  begin
    repeat (1000) @(posedge clk);
    fail_count++;
    results;
  end
  initial
  begin
    repeat (5) @(posedge clk);
    chk(cond, 8'hd0);
    rst_n <= 1'b1;
    foreach (rows[i])
    begin
      run(rows[i][47:40], rows[i][39:32]);
      chk(acc_a, rows[i][31:24]);
      chk(acc_b, rows[i][23:16]);
      chk(cond, rows[i][15:8]);
      #4;
      chk(opnd, rows[i][7:0]);
    end
    $display("reset and opcode table done");
    run(8'h0e, 8'h00);
    chk({cond[4], take}, 8'h02);
    @(posedge clk) bnd <= 1'b1;
    #1;
    chk({cond[4], take}, 8'h00);
    @(posedge clk) bnd <= 1'b0;
    #1;
    chk(take, 8'h01);
    $display("interrupt mask test done");
    @(posedge clk) en <= 1'b0;
    run(8'h43, 8'h00);
    chk(acc_a, 8'h00);
    chk(cond, 8'hc9);
    @(posedge clk) en <= 1'b1;
    run(8'h01, 8'h00);
    chk(ill, 8'h01);
    chk(cond, 8'hc9);
    $display("enable and unknown opcode test done");
    results;
  end
endmodule
`default_nettype wire
